/* File: core/gphy_regs_pkg.sv */
// Shared constants for the gigabit PHY next-page and control register bank
`default_nettype none
package gphy_regs_pkg;

  // ---------------------------------------------------------------
  // Register map: printed offsets are word indices, byte address = 4 * index
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_NEXT_PAGE_RECEIVE = 6'h08;
  localparam logic [5:0] IDX_GBIT_CONTROL = 6'h09;
  localparam logic [31:0] ADDR_NEXT_PAGE_RECEIVE =
    {24'h000000, IDX_NEXT_PAGE_RECEIVE, 2'b00};
  localparam logic [31:0] ADDR_GBIT_CONTROL =
    {24'h000000, IDX_GBIT_CONTROL, 2'b00};

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int POS_MESSAGE_PAGE = 13;
  localparam int POS_TOGGLE = 11;
  localparam int POS_CODE_LO = 0;
  localparam int CODE_W = 11;
  localparam int POS_TEST_MODE_LO = 13;
  localparam int POS_MANUAL_MS_EN = 12;
  localparam int POS_MS_VALUE = 11;
  localparam int POS_ADV_REPEATER = 10;
  localparam int POS_ADV_GIG_FULL = 9;
  localparam int POS_ADV_GIG_HALF = 8;

  // ---------------------------------------------------------------
  // Reset values and strap encodings
  // ---------------------------------------------------------------
  localparam logic [CODE_W-1:0] RST_CODE = 11'h000;
  localparam logic RST_TOGGLE = 1'b0;
  localparam logic RST_MESSAGE_PAGE = 1'b0;
  localparam logic [2:0] RST_TEST_MODE = 3'h0;
  localparam logic RST_MANUAL_MS_EN = 1'b0;
  localparam logic RST_MS_VALUE = 1'b0;
  localparam logic [1:0] STRAP_SPEED_GIG = 2'h2;

  // ---------------------------------------------------------------
  // Test mode encodings and AHB constants
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TM_NORMAL = 3'b000,
    TM_MODE1 = 3'b001,
    TM_MODE2 = 3'b010,
    TM_MODE3 = 3'b011,
    TM_MODE4 = 3'b100
  } test_mode_t;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage
`default_nettype wire

/* File: core/test_mode_decode.sv */
// Decoder from the three-bit test mode field to one-hot mode selects
`timescale 1ns/1ns
`default_nettype none
module test_mode_decode (
  // Field
  input wire logic [2:0] mode_field,
  // Selects
  output logic normal_operation,
  output logic [3:0] test_mode_sel
);

  always_comb begin
    normal_operation = 1'b0;
    test_mode_sel = 4'h0;
    case (gphy_regs_pkg::test_mode_t'(mode_field))
      gphy_regs_pkg::TM_NORMAL: normal_operation = 1'b1;
      gphy_regs_pkg::TM_MODE1: test_mode_sel = 4'h1;
      gphy_regs_pkg::TM_MODE2: test_mode_sel = 4'h2;
      gphy_regs_pkg::TM_MODE3: test_mode_sel = 4'h4;
      gphy_regs_pkg::TM_MODE4: test_mode_sel = 4'h8;
      // Undefined codes fall back to normal operation
      default: normal_operation = 1'b1;
    endcase
  end

endmodule
`default_nettype wire

/* File: core/strap_defaults.sv */
// Strap-derived reset defaults for the advertisement bits
`timescale 1ns/1ns
`default_nettype none
module strap_defaults (
  // Strap levels
  input wire logic strap_an_enable,
  input wire logic strap_duplex,
  input wire logic [1:0] strap_speed,
  input wire logic strap_multi_port,
  // Defaults
  output logic def_repeater,
  output logic def_gig_full,
  output logic def_gig_half
);

  logic gig_strap;

  // Without negotiation the straps do not steer the advertisement
  always_comb begin
    gig_strap = (strap_speed == gphy_regs_pkg::STRAP_SPEED_GIG);
    if (strap_an_enable) begin
      def_repeater = strap_multi_port;
      def_gig_full = gig_strap && strap_duplex;
      def_gig_half = gig_strap && !strap_duplex;
    end else begin
      def_repeater = 1'b0;
      def_gig_full = 1'b1;
      def_gig_half = 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: core/gphy_np_ctrl_regs.sv */
// AHB-Lite register bank: partner next-page receive and gigabit control
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Toggle flag reads the inverse of the partner's last toggle bit.
// - Each received next page code lands in bits 10 to 0.
// - Message page flag set means the code is a formatted message.
// - After reset the received code reads all zeros.
// - Control bits 15 to 13 pick normal operation or test modes 1-4.
// - Bit 12 enables manual master/slave; bit 11 then forces the role.
// - Bit 10 advertises repeater or end station; strap sets its default.
// - Bit 9 advertises gigabit full duplex; straps set its default.
// - Bit 8 advertises gigabit half duplex; straps set its default.
// - Control bits 7 to 0 ignore writes and read as zero.
module gphy_np_ctrl_regs (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Next page from the negotiation engine
  input wire logic np_rx_valid,
  input wire logic np_rx_toggle,
  input wire logic np_rx_message_page,
  input wire logic [10:0] np_rx_code,
  // Strap levels
  input wire logic strap_an_enable,
  input wire logic strap_duplex,
  input wire logic [1:0] strap_speed,
  input wire logic strap_multi_port,
  // Received page as seen by the rest of the PHY
  output logic partner_toggle_flag,
  output logic message_page_flag,
  output logic [10:0] rx_code,
  output logic code_is_message,
  // Control outputs
  output logic normal_operation,
  output logic [3:0] test_mode_sel,
  output logic force_master,
  output logic force_slave,
  output logic adv_repeater,
  output logic adv_gig_full,
  output logic adv_gig_half
);

  // ---------------------------------------------------------------
  // Address phase capture
  // ---------------------------------------------------------------
  logic ap_valid;
  logic dp_write;
  logic dp_ctrl;
  logic dp_rx;

  function automatic logic word_at(input logic [31:0] a,
                                   input logic [31:0] target);
    word_at = (a == target);
  endfunction

  assign ap_valid = hsel && htrans[1] && hready;

  // Only whole-word writes reach the registers; narrower ones are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_ctrl <= 1'b0;
      dp_rx <= 1'b0;
    end else if (hready) begin
      dp_write <= ap_valid && hwrite && (hsize == gphy_regs_pkg::HSIZE_WORD);
      dp_ctrl <= ap_valid &&
        word_at(haddr, gphy_regs_pkg::ADDR_GBIT_CONTROL);
      dp_rx <= ap_valid &&
        word_at(haddr, gphy_regs_pkg::ADDR_NEXT_PAGE_RECEIVE);
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ---------------------------------------------------------------
  // Strap defaults, loaded on the first edge after reset release
  // ---------------------------------------------------------------
  logic def_repeater;
  logic def_gig_full;
  logic def_gig_half;
  logic strap_loaded;

  strap_defaults u_strap (
    .strap_an_enable(strap_an_enable),
    .strap_duplex(strap_duplex),
    .strap_speed(strap_speed),
    .strap_multi_port(strap_multi_port),
    .def_repeater(def_repeater),
    .def_gig_full(def_gig_full),
    .def_gig_half(def_gig_half)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_loaded <= 1'b0;
    end else begin
      strap_loaded <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic [2:0] test_mode;
  logic manual_ms_en;
  logic ms_value;
  logic [2:0] next_test_mode;
  logic next_manual_ms_en;
  logic next_ms_value;
  logic next_adv_repeater;
  logic next_adv_gig_full;
  logic next_adv_gig_half;
  logic ctrl_wr;

  assign ctrl_wr = dp_write && dp_ctrl;

  // The next value also feeds the read path, so a read right behind a
  // write sees the written data without a wait state
  always_comb begin
    next_test_mode = test_mode;
    next_manual_ms_en = manual_ms_en;
    next_ms_value = ms_value;
    next_adv_repeater = adv_repeater;
    next_adv_gig_full = adv_gig_full;
    next_adv_gig_half = adv_gig_half;
    if (!strap_loaded) begin
      next_adv_repeater = def_repeater;
      next_adv_gig_full = def_gig_full;
      next_adv_gig_half = def_gig_half;
    end else if (ctrl_wr) begin
      next_test_mode = hwdata[gphy_regs_pkg::POS_TEST_MODE_LO +: 3];
      next_manual_ms_en = hwdata[gphy_regs_pkg::POS_MANUAL_MS_EN];
      next_ms_value = hwdata[gphy_regs_pkg::POS_MS_VALUE];
      next_adv_repeater = hwdata[gphy_regs_pkg::POS_ADV_REPEATER];
      next_adv_gig_full = hwdata[gphy_regs_pkg::POS_ADV_GIG_FULL];
      next_adv_gig_half = hwdata[gphy_regs_pkg::POS_ADV_GIG_HALF];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      test_mode <= gphy_regs_pkg::RST_TEST_MODE;
      manual_ms_en <= gphy_regs_pkg::RST_MANUAL_MS_EN;
      ms_value <= gphy_regs_pkg::RST_MS_VALUE;
      adv_repeater <= 1'b0;
      adv_gig_full <= 1'b0;
      adv_gig_half <= 1'b0;
    end else begin
      test_mode <= next_test_mode;
      manual_ms_en <= next_manual_ms_en;
      ms_value <= next_ms_value;
      adv_repeater <= next_adv_repeater;
      adv_gig_full <= next_adv_gig_full;
      adv_gig_half <= next_adv_gig_half;
    end
  end

  // Role is only forced while manual configuration is on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_master <= 1'b0;
      force_slave <= 1'b0;
    end else begin
      force_master <= next_manual_ms_en && next_ms_value;
      force_slave <= next_manual_ms_en && !next_ms_value;
    end
  end

  test_mode_decode u_test_mode (
    .mode_field(test_mode),
    .normal_operation(normal_operation),
    .test_mode_sel(test_mode_sel)
  );

  // ---------------------------------------------------------------
  // Next page receive register
  // ---------------------------------------------------------------
  logic next_toggle;
  logic next_message_page;
  logic [10:0] next_rx_code;

  // Bus writes do not enter here at all; only the negotiation engine does
  always_comb begin
    next_toggle = partner_toggle_flag;
    next_message_page = message_page_flag;
    next_rx_code = rx_code;
    if (np_rx_valid) begin
      next_toggle = !np_rx_toggle;
      next_message_page = np_rx_message_page;
      next_rx_code = np_rx_code;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      partner_toggle_flag <= gphy_regs_pkg::RST_TOGGLE;
      message_page_flag <= gphy_regs_pkg::RST_MESSAGE_PAGE;
      rx_code <= gphy_regs_pkg::RST_CODE;
    end else begin
      partner_toggle_flag <= next_toggle;
      message_page_flag <= next_message_page;
      rx_code <= next_rx_code;
    end
  end

  assign code_is_message = message_page_flag;

  // ---------------------------------------------------------------
  // Read data, loaded in the address phase
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h00000000;
    if (word_at(haddr, gphy_regs_pkg::ADDR_GBIT_CONTROL)) begin
      next_rdata[gphy_regs_pkg::POS_TEST_MODE_LO +: 3] = next_test_mode;
      next_rdata[gphy_regs_pkg::POS_MANUAL_MS_EN] = next_manual_ms_en;
      next_rdata[gphy_regs_pkg::POS_MS_VALUE] = next_ms_value;
      next_rdata[gphy_regs_pkg::POS_ADV_REPEATER] = next_adv_repeater;
      next_rdata[gphy_regs_pkg::POS_ADV_GIG_FULL] = next_adv_gig_full;
      next_rdata[gphy_regs_pkg::POS_ADV_GIG_HALF] = next_adv_gig_half;
    end else if (word_at(haddr, gphy_regs_pkg::ADDR_NEXT_PAGE_RECEIVE)) begin
      next_rdata[gphy_regs_pkg::POS_MESSAGE_PAGE] = next_message_page;
      next_rdata[gphy_regs_pkg::POS_TOGGLE] = next_toggle;
      next_rdata[gphy_regs_pkg::POS_CODE_LO +: 11] = next_rx_code;
    end
  end

  // Low control bits are never set above, so they read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ap_valid && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_ctrl_write_addr;
    ap_valid && hwrite && (hsize == gphy_regs_pkg::HSIZE_WORD) &&
      word_at(haddr, gphy_regs_pkg::ADDR_GBIT_CONTROL);
  endsequence

  sequence s_ctrl_read_addr;
    ap_valid && !hwrite && word_at(haddr, gphy_regs_pkg::ADDR_GBIT_CONTROL);
  endsequence

  sequence s_rx_write_addr;
    ap_valid && hwrite &&
      word_at(haddr, gphy_regs_pkg::ADDR_NEXT_PAGE_RECEIVE);
  endsequence

  chk_toggle_inverse: assert property (
    np_rx_valid |=> partner_toggle_flag == !$past(np_rx_toggle))
    else $error("toggle flag is not the inverse of the received toggle");

  chk_code_capture: assert property (
    np_rx_valid ##1 !np_rx_valid |-> rx_code == $past(np_rx_code))
    else $error("received code not captured");

  chk_message_kind: assert property (
    np_rx_valid |=> code_is_message == $past(np_rx_message_page))
    else $error("message page indication does not follow the page");

  chk_code_reset: assert property (
    $rose(hresetn) |-> rx_code == 11'h000 && !partner_toggle_flag)
    else $error("received code not zero after reset");

  chk_test_field: assert property (
    s_ctrl_write_addr ##1 hready |=>
      test_mode == $past(hwdata[15:13]) &&
      normal_operation == ($past(hwdata[15:13]) == 3'b000 ||
        $past(hwdata[15:13]) > 3'b100))
    else $error("test mode field not written or decoded");

  chk_manual_role: assert property (
    (force_master || force_slave) |->
      manual_ms_en && (force_master == ms_value) && !(force_master && force_slave))
    else $error("role forced without manual enable");

  chk_strap_load: assert property (
    $rose(hresetn) |=> adv_repeater ==
      ($past(strap_an_enable) ? $past(strap_multi_port) : 1'b0))
    else $error("device type default does not follow the strap");

  chk_full_default: assert property (
    $rose(hresetn) && strap_an_enable && strap_speed != 2'h2 |=> !adv_gig_full)
    else $error("full duplex advertised against the straps");

  chk_half_default: assert property (
    $rose(hresetn) && strap_an_enable && strap_duplex |=> !adv_gig_half)
    else $error("half duplex advertised against the straps");

  chk_low_bits_zero: assert property (
    s_ctrl_read_addr |=> hrdata[7:0] == 8'h00)
    else $error("reserved control bits read non-zero");

  chk_rx_write_blocked: assert property (
    s_rx_write_addr ##1 !np_rx_valid |=> $stable(rx_code) &&
      $stable(partner_toggle_flag))
    else $error("bus write changed the received page");

  chk_mode_onehot: assert property (
    test_mode_sel == {test_mode == 3'h4, test_mode == 3'h3,
      test_mode == 3'h2, test_mode == 3'h1})
    else $error("test mode select does not match the field");

  chk_role_released: assert property (
    !manual_ms_en |-> !force_master && !force_slave)
    else $error("role forced while manual configuration is off");

  chk_gig_no_strap: assert property (
    $rose(hresetn) && !strap_an_enable |=> adv_gig_full && adv_gig_half)
    else $error("gigabit advertisement not set without negotiation");

  // Catches a page register that drifts between pages
  chk_rx_hold: assert property (
    !np_rx_valid |=> $stable(rx_code) && $stable(partner_toggle_flag) &&
      $stable(message_page_flag))
    else $error("received page changed with no page received");

endmodule
`default_nettype wire

/* File: test/mgmt_master.sv */
// Management station model: AHB-Lite master doing single word transfers
`timescale 1ns/1ns
`default_nettype none
module mgmt_master (
  // Bus clock and answer
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Raised when the slave never answers
  output logic hang
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    hang = 1'b0;
  end

  // Bounded wait: a silent slave must not stall the run
  task automatic wait_ready;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hready !== 1'b1 && i < 16);
    if (hready !== 1'b1)
      hang <= 1'b1;
  endtask

  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= gphy_regs_pkg::HSIZE_WORD;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= w ? d : ~d;
    wait_ready();
    q = hrdata;
  endtask
endmodule
`default_nettype wire

/* File: test/gphy_np_ctrl_regs_test.sv */
// Self-checking bench for the next-page receive and gigabit control bank
`timescale 1ns/1ns
`default_nettype none
module gphy_np_ctrl_regs_test;
  localparam logic [31:0] CTRL = gphy_regs_pkg::ADDR_GBIT_CONTROL;
  localparam logic [31:0] RXP = gphy_regs_pkg::ADDR_NEXT_PAGE_RECEIVE;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, hang;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, strap_speed;
  logic [2:0] hsize;
  logic np_rx_valid, np_rx_toggle, np_rx_message_page;
  logic [10:0] np_rx_code, rx_code;
  logic strap_an_enable, strap_duplex, strap_multi_port;
  logic partner_toggle_flag, message_page_flag, code_is_message;
  logic normal_operation, force_master, force_slave;
  logic adv_repeater, adv_gig_full, adv_gig_half;
  logic [3:0] test_mode_sel;
  int n_errors = 0;
  int tests_run = 0;

  mgmt_master m (.hclk(hclk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hang(hang));

  gphy_np_ctrl_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .np_rx_valid(np_rx_valid),
    .np_rx_toggle(np_rx_toggle), .np_rx_message_page(np_rx_message_page),
    .np_rx_code(np_rx_code), .strap_an_enable(strap_an_enable),
    .strap_duplex(strap_duplex), .strap_speed(strap_speed),
    .strap_multi_port(strap_multi_port),
    .partner_toggle_flag(partner_toggle_flag),
    .message_page_flag(message_page_flag), .rx_code(rx_code),
    .code_is_message(code_is_message),
    .normal_operation(normal_operation), .test_mode_sel(test_mode_sel),
    .force_master(force_master), .force_slave(force_slave),
    .adv_repeater(adv_repeater), .adv_gig_full(adv_gig_full),
    .adv_gig_half(adv_gig_half));

  // ---------------------------------------------------------------
  // Clock, checking and verdict
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge hang) begin
    n_errors++;
    report_and_stop();
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    m.xfer(1'b1, a, d, x);
    #1;
  endtask

  task automatic rd(input logic [31:0] a);
    m.xfer(1'b0, a, 32'h0, q);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Straps load the advertisement defaults at reset release
  task automatic sc_reset(input logic an, input logic mp,
                          input logic [1:0] sp, input logic dp,
                          input logic [31:0] exp);
    @(posedge hclk);
    hresetn <= 1'b0;
    strap_an_enable <= an;
    strap_multi_port <= mp;
    strap_speed <= sp;
    strap_duplex <= dp;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(CTRL);
    chk(q, exp);
    rd(RXP);
    chk(q, 32'h0);
    chk({31'h0, normal_operation}, 32'h1);
  endtask

  task automatic sc_test_modes;
    for (int i = 0; i < 5; i++) begin
      wr(CTRL, (i << 13) | 32'h00ff);
      chk({31'h0, normal_operation}, {31'h0, i == 0});
      chk({28'h0, test_mode_sel}, i == 0 ? 0 : 1 << (i - 1));
      rd(CTRL);
      chk(q, i << 13);
    end
  endtask

  task automatic sc_master_slave;
    logic [15:0] v[3] = '{16'h1800, 16'h1000, 16'h0800};
    logic [1:0] e[3] = '{2'b10, 2'b01, 2'b00};
    for (int i = 0; i < 3; i++) begin
      wr(CTRL, {16'h0, v[i]});
      chk({30'h0, force_master, force_slave}, {30'h0, e[i]});
    end
  endtask

  task automatic sc_advertise;
    for (int i = 8; i < 11; i++) begin
      wr(CTRL, 1 << i);
      chk({29'h0, adv_repeater, adv_gig_full, adv_gig_half},
          1 << (i - 8));
      rd(CTRL);
      chk(q, 1 << i);
    end
  endtask

  // Back-to-back pages, then software tries to overwrite them
  task automatic sc_next_page;
    @(posedge hclk);
    np_rx_valid <= 1'b1;
    np_rx_toggle <= 1'b1;
    np_rx_message_page <= 1'b0;
    np_rx_code <= 11'h2aa;
    @(posedge hclk);
    np_rx_toggle <= 1'b0;
    np_rx_message_page <= 1'b1;
    np_rx_code <= 11'h555;
    #1;
    chk({31'h0, partner_toggle_flag}, 32'h0);
    chk({21'h0, rx_code}, 32'h2aa);
    chk({30'h0, code_is_message, message_page_flag}, 32'h0);
    @(posedge hclk);
    np_rx_valid <= 1'b0;
    np_rx_toggle <= 1'b1;
    np_rx_code <= 11'h0ff;
    #1;
    chk({30'h0, code_is_message, message_page_flag}, 32'h3);
    wr(RXP, 32'h0000ffff);
    rd(RXP);
    chk(q, 32'h00002d55);
    wr(CTRL, 32'h0000e700);
    chk({31'h0, normal_operation}, 32'h1);
    chk({28'h0, test_mode_sel}, 32'h0);
    wr(32'h00000028, 32'h0000ffff);
    rd(32'h00000028);
    chk(q, 32'h0);
    rd(CTRL);
    chk(q, 32'h0000e700);
  endtask

  initial begin
    hresetn = 1'b0;
    np_rx_valid = 1'b0;
    np_rx_toggle = 1'b0;
    np_rx_message_page = 1'b0;
    np_rx_code = 11'h0;
    strap_an_enable = 1'b1;
    strap_duplex = 1'b1;
    strap_speed = gphy_regs_pkg::STRAP_SPEED_GIG;
    strap_multi_port = 1'b1;
    sc_reset(1'b1, 1'b1, 2'h2, 1'b1, 32'h0600);
    sc_test_modes();
    sc_master_slave();
    sc_advertise();
    sc_next_page();
    sc_reset(1'b1, 1'b0, 2'h2, 1'b0, 32'h0100);
    sc_reset(1'b1, 1'b1, 2'h1, 1'b1, 32'h0400);
    sc_reset(1'b0, 1'b1, 2'h0, 1'b0, 32'h0300);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
